// ---- src/jmpp_top.sv ----
`timescale 1ns/100ps
// Functional notes
// RQ1: Four-bit instruction register, sixteen codes
// RQ2: All shift registers move LSB first
// RQ3: Only four test pins needed
// RQ4: Port needs fuse, disable bit; reset clears bit
// RQ5: Code C selects one-bit reset chain
// RQ6: Core reset follows reset chain immediately
// RQ7: Time-out after release set by fuses
// RQ8: Programmer resets core before unlocking
// RQ9: Code 4 selects sixteen-bit unlock register
// RQ10: Update compares signature, unlocks on match
// RQ11: Unlock register zero at power-on
// RQ12: Code 5 selects fifteen-bit command register
// RQ13: Capture loads previous result, shift exchanges
// RQ14: Update presents command to flash control
// RQ15: Idle pass issues one execute clock
// RQ16: Code 6 selects 1024-bit page load chain
// RQ17: Completed bytes move during shift, not update
// RQ18: Code 7 selects 1032-bit read chain
// RQ19: Page read fetches bytes, ignores data in
// RQ20: Page chains only when first in chain
// RQ21: Idle serves execution and resting
// RQ22: Flash write begins with enter-write command
// RQ23: Without unlock, command and page ignored
module jmpp_top (
  // System clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Chip pins and fuses
  input wire logic ext_rst_n,
  input wire logic test_port_enable_fuse,
  input wire logic [1:0] clk_option_fuse,
  // Disable bit write from the core
  input wire logic disable_wr,
  input wire logic disable_wdata,
  output logic test_port_disable_bit,
  output logic core_reset,
  // Flash control
  output logic [14:0] flash_cmd,
  output logic flash_cmd_load,
  output logic flash_exec,
  input wire logic flash_result_valid,
  input wire logic [14:0] flash_result,
  // Page buffer
  output logic page_wr,
  output logic [6:0] page_wr_addr,
  output logic [7:0] page_wr_data,
  output logic [6:0] page_rd_addr,
  input wire logic [7:0] page_rd_data
);

  // ---------------------------------------------------------------
  // Reset synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic [1:0] trst_sync_ff;
  logic mrst_n;
  logic trst_n;

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};

  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n)
      trst_sync_ff <= 2'h0;
    else
      trst_sync_ff <= {trst_sync_ff[0], 1'b1};

  assign mrst_n = rst_sync_ff[1];
  assign trst_n = trst_sync_ff[1];

  // ---------------------------------------------------------------
  // Core side: disable bit and core reset
  // ---------------------------------------------------------------
  logic [1:0] ext_sync_ff;
  logic [1:0] ext_low_cnt_ff;
  logic disable_ff;
  logic [1:0] chain_sync_ff;
  logic [11:0] to_cnt_ff;
  logic core_reset_ff;
  logic [11:0] to_sel;

  always_ff @(posedge mclk or negedge mrst_n)
    if (!mrst_n)
      ext_sync_ff <= 2'h3;
    else
      ext_sync_ff <= {ext_sync_ff[0], ext_rst_n};

  always_ff @(posedge mclk or negedge mrst_n)
    if (!mrst_n)
      ext_low_cnt_ff <= 2'h0;
    else if (ext_sync_ff[1])
      ext_low_cnt_ff <= 2'h0;
    else if (ext_low_cnt_ff != jmpp_pkg::EXT_RST_CLR_CYCLES)
      ext_low_cnt_ff <= ext_low_cnt_ff + 2'h1;

  // External reset beats a core write; the core is held anyway
  always_ff @(posedge mclk or negedge mrst_n)
    if (!mrst_n)
      disable_ff <= 1'b0;
    else if (!ext_sync_ff[1] && ext_low_cnt_ff == 2'h1)
      disable_ff <= 1'b0; // RQ4
    else if (disable_wr && ext_sync_ff[1])
      disable_ff <= disable_wdata;

  always_comb
  begin
    unique case (clk_option_fuse)
      2'h0: to_sel = jmpp_pkg::TIMEOUT0_CYC;
      2'h1: to_sel = jmpp_pkg::TIMEOUT1_CYC;
      2'h2: to_sel = jmpp_pkg::TIMEOUT2_CYC;
      2'h3: to_sel = jmpp_pkg::TIMEOUT3_CYC;
    endcase
  end

  logic rst_chain_ff;

  always_ff @(posedge mclk or negedge mrst_n)
    if (!mrst_n)
      chain_sync_ff <= 2'h0;
    else
      chain_sync_ff <= {chain_sync_ff[0], rst_chain_ff};

  // Chain bit is not latched, so reset follows the shift itself
  always_ff @(posedge mclk or negedge mrst_n)
    if (!mrst_n)
    begin
      to_cnt_ff <= 12'h000;
      core_reset_ff <= 1'b0;
    end
    else if (chain_sync_ff[1])
    begin
      to_cnt_ff <= to_sel; // RQ7
      core_reset_ff <= 1'b1; // RQ6
    end
    else if (to_cnt_ff != 12'h000)
    begin
      to_cnt_ff <= to_cnt_ff - 12'h001; // RQ7
      core_reset_ff <= 1'b1;
    end
    else
      core_reset_ff <= 1'b0;

  // ---------------------------------------------------------------
  // Test port controller
  // ---------------------------------------------------------------
  jmpp_pkg::jmpp_tap_type tap_ff;
  jmpp_pkg::jmpp_tap_type nxt_tap;
  logic [1:0] pen_sync_ff;
  logic port_en;

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      pen_sync_ff <= 2'h0;
    else
      pen_sync_ff <= {pen_sync_ff[0], test_port_enable_fuse & ~disable_ff};

  assign port_en = pen_sync_ff[1]; // RQ4

  always_comb
  begin
    unique case (tap_ff)
      jmpp_pkg::TAP_RESET: nxt_tap = tms ? jmpp_pkg::TAP_RESET : jmpp_pkg::TAP_IDLE;
      jmpp_pkg::TAP_IDLE: nxt_tap = tms ? jmpp_pkg::TAP_SEL_DR : jmpp_pkg::TAP_IDLE; // RQ21
      jmpp_pkg::TAP_SEL_DR: nxt_tap = tms ? jmpp_pkg::TAP_SEL_IR : jmpp_pkg::TAP_CAP_DR;
      jmpp_pkg::TAP_CAP_DR: nxt_tap = tms ? jmpp_pkg::TAP_EXIT1_DR : jmpp_pkg::TAP_SHIFT_DR;
      jmpp_pkg::TAP_SHIFT_DR: nxt_tap = tms ? jmpp_pkg::TAP_EXIT1_DR : jmpp_pkg::TAP_SHIFT_DR;
      jmpp_pkg::TAP_EXIT1_DR: nxt_tap = tms ? jmpp_pkg::TAP_UPD_DR : jmpp_pkg::TAP_PAUSE_DR;
      jmpp_pkg::TAP_PAUSE_DR: nxt_tap = tms ? jmpp_pkg::TAP_EXIT2_DR : jmpp_pkg::TAP_PAUSE_DR;
      jmpp_pkg::TAP_EXIT2_DR: nxt_tap = tms ? jmpp_pkg::TAP_UPD_DR : jmpp_pkg::TAP_SHIFT_DR;
      jmpp_pkg::TAP_UPD_DR: nxt_tap = tms ? jmpp_pkg::TAP_SEL_DR : jmpp_pkg::TAP_IDLE;
      jmpp_pkg::TAP_SEL_IR: nxt_tap = tms ? jmpp_pkg::TAP_RESET : jmpp_pkg::TAP_CAP_IR;
      jmpp_pkg::TAP_CAP_IR: nxt_tap = tms ? jmpp_pkg::TAP_EXIT1_IR : jmpp_pkg::TAP_SHIFT_IR;
      jmpp_pkg::TAP_SHIFT_IR: nxt_tap = tms ? jmpp_pkg::TAP_EXIT1_IR : jmpp_pkg::TAP_SHIFT_IR;
      jmpp_pkg::TAP_EXIT1_IR: nxt_tap = tms ? jmpp_pkg::TAP_UPD_IR : jmpp_pkg::TAP_PAUSE_IR;
      jmpp_pkg::TAP_PAUSE_IR: nxt_tap = tms ? jmpp_pkg::TAP_EXIT2_IR : jmpp_pkg::TAP_PAUSE_IR;
      jmpp_pkg::TAP_EXIT2_IR: nxt_tap = tms ? jmpp_pkg::TAP_UPD_IR : jmpp_pkg::TAP_SHIFT_IR;
      jmpp_pkg::TAP_UPD_IR: nxt_tap = tms ? jmpp_pkg::TAP_SEL_DR : jmpp_pkg::TAP_IDLE;
    endcase
  end

  // Four pins only; a disabled port parks in reset
  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      tap_ff <= jmpp_pkg::TAP_RESET;
    else if (!port_en)
      tap_ff <= jmpp_pkg::TAP_RESET; // RQ3
    else
      tap_ff <= nxt_tap;

  // ---------------------------------------------------------------
  // Instruction register
  // ---------------------------------------------------------------
  logic [3:0] ir_sh_ff;
  logic [3:0] ir_ff;

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      ir_sh_ff <= jmpp_pkg::IR_BYPASS;
    else if (tap_ff == jmpp_pkg::TAP_CAP_IR)
      ir_sh_ff <= jmpp_pkg::IR_CAPTURE_VAL; // RQ1
    else if (tap_ff == jmpp_pkg::TAP_SHIFT_IR)
      ir_sh_ff <= {tdi, ir_sh_ff[3:1]}; // RQ2

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      ir_ff <= jmpp_pkg::IR_BYPASS;
    else if (tap_ff == jmpp_pkg::TAP_RESET)
      ir_ff <= jmpp_pkg::IR_BYPASS;
    else if (tap_ff == jmpp_pkg::TAP_UPD_IR)
      ir_ff <= ir_sh_ff; // RQ1

  // ---------------------------------------------------------------
  // Reset chain, unlock register, bypass
  // ---------------------------------------------------------------
  logic shift_dr;
  logic unlocked_ff;
  logic [15:0] unlock_sh_ff;
  logic bypass_ff;
  logic prog_cmd;
  logic prog_load;
  logic prog_read;

  assign shift_dr = (tap_ff == jmpp_pkg::TAP_SHIFT_DR);
  assign prog_cmd = unlocked_ff && ir_ff == jmpp_pkg::IR_COMMAND; // RQ23
  assign prog_load = unlocked_ff && ir_ff == jmpp_pkg::IR_PAGE_LOAD; // RQ23
  assign prog_read = unlocked_ff && ir_ff == jmpp_pkg::IR_PAGE_READ; // RQ23

  // Not cleared by controller reset: the instruction leaves the TAP alone
  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      rst_chain_ff <= 1'b0;
    else if (shift_dr && ir_ff == jmpp_pkg::IR_RESET_CHAIN)
      rst_chain_ff <= tdi; // RQ5

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      unlock_sh_ff <= jmpp_pkg::UNLOCK_RESET; // RQ11
    else if (shift_dr && ir_ff == jmpp_pkg::IR_UNLOCK)
      unlock_sh_ff <= {tdi, unlock_sh_ff[15:1]}; // RQ9

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      unlocked_ff <= 1'b0; // RQ11
    else if (tap_ff == jmpp_pkg::TAP_UPD_DR && ir_ff == jmpp_pkg::IR_UNLOCK)
      unlocked_ff <= (unlock_sh_ff == jmpp_pkg::UNLOCK_SIGNATURE); // RQ10

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      bypass_ff <= 1'b0;
    else if (shift_dr)
      bypass_ff <= tdi;

  // ---------------------------------------------------------------
  // Command register and crossings
  // ---------------------------------------------------------------
  logic [14:0] cmd_sh_ff;
  logic [14:0] cmd_ff;
  logic cmd_tgl_ff;
  logic exec_tgl_ff;
  logic [14:0] res_hold_ff;
  logic res_tgl_ff;
  logic [2:0] res_sync_ff;
  logic [14:0] res_ff;

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      res_sync_ff <= 3'h0;
    else
      res_sync_ff <= {res_sync_ff[1:0], res_tgl_ff};

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      res_ff <= jmpp_pkg::CMD_RESET;
    else if (res_sync_ff[2] != res_sync_ff[1])
      res_ff <= res_hold_ff;

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      cmd_sh_ff <= jmpp_pkg::CMD_RESET;
    else if (tap_ff == jmpp_pkg::TAP_CAP_DR && prog_cmd)
      cmd_sh_ff <= res_ff; // RQ13
    else if (shift_dr && prog_cmd)
      cmd_sh_ff <= {tdi, cmd_sh_ff[14:1]}; // RQ12

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
    begin
      cmd_ff <= jmpp_pkg::CMD_RESET;
      cmd_tgl_ff <= 1'b0;
    end
    else if (tap_ff == jmpp_pkg::TAP_UPD_DR && prog_cmd)
    begin
      cmd_ff <= cmd_sh_ff; // RQ14
      cmd_tgl_ff <= ~cmd_tgl_ff;
    end

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      exec_tgl_ff <= 1'b0;
    else if (port_en && prog_cmd && nxt_tap == jmpp_pkg::TAP_IDLE && tap_ff != jmpp_pkg::TAP_IDLE)
      exec_tgl_ff <= ~exec_tgl_ff; // RQ15

  // ---------------------------------------------------------------
  // Page load and page read byte engine
  // ---------------------------------------------------------------
  logic [7:0] pg_sh_ff;
  logic [2:0] pg_bit_ff;
  logic [6:0] pg_byte_ff;
  logic [7:0] pl_data_ff;
  logic [6:0] pl_idx_ff;
  logic pl_tgl_ff;
  logic [6:0] rd_idx_ff;
  logic rd_req_tgl_ff;
  logic rd_ack_tgl_ff;
  logic [2:0] ack_sync_ff;
  logic [7:0] rd_hold_ff;
  logic [7:0] rd_next_ff;
  logic byte_done;

  assign byte_done = shift_dr && pg_bit_ff == 3'h7;

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      ack_sync_ff <= 3'h0;
    else
      ack_sync_ff <= {ack_sync_ff[1:0], rd_ack_tgl_ff};

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
      rd_next_ff <= 8'h00;
    else if (ack_sync_ff[2] != ack_sync_ff[1])
      rd_next_ff <= rd_hold_ff;

  // Read chain: first byte out is padding while byte 0 is fetched
  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
    begin
      pg_sh_ff <= 8'h00;
      pg_bit_ff <= 3'h0;
      pg_byte_ff <= 7'h00;
    end
    else if (tap_ff == jmpp_pkg::TAP_CAP_DR)
    begin
      pg_sh_ff <= 8'h00; // RQ18
      pg_bit_ff <= 3'h0;
      pg_byte_ff <= 7'h00;
    end
    else if (shift_dr && (prog_load || prog_read))
    begin
      pg_bit_ff <= pg_bit_ff + 3'h1;
      if (prog_read && byte_done)
        pg_sh_ff <= rd_next_ff; // RQ19
      else if (prog_read)
        pg_sh_ff <= {1'b0, pg_sh_ff[7:1]}; // RQ19
      else
        pg_sh_ff <= {tdi, pg_sh_ff[7:1]}; // RQ16
      if (byte_done && prog_load)
        pg_byte_ff <= pg_byte_ff + 7'h01;
    end

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
    begin
      pl_data_ff <= 8'h00;
      pl_idx_ff <= 7'h00;
      pl_tgl_ff <= 1'b0;
    end
    else if (byte_done && prog_load)
    begin
      pl_data_ff <= {tdi, pg_sh_ff[7:1]}; // RQ17
      pl_idx_ff <= pg_byte_ff;
      pl_tgl_ff <= ~pl_tgl_ff;
    end

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
    begin
      rd_idx_ff <= 7'h00;
      rd_req_tgl_ff <= 1'b0;
    end
    else if (tap_ff == jmpp_pkg::TAP_CAP_DR && prog_read)
    begin
      rd_idx_ff <= 7'h00;
      rd_req_tgl_ff <= ~rd_req_tgl_ff;
    end
    else if (byte_done && prog_read)
    begin
      rd_idx_ff <= rd_idx_ff + 7'h01;
      rd_req_tgl_ff <= ~rd_req_tgl_ff;
    end

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  always_ff @(negedge tck or negedge trst_n)
    if (!trst_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo_oe <= shift_dr || tap_ff == jmpp_pkg::TAP_SHIFT_IR;
      if (tap_ff == jmpp_pkg::TAP_SHIFT_IR)
        tdo <= ir_sh_ff[0]; // RQ2
      else if (ir_ff == jmpp_pkg::IR_RESET_CHAIN)
        tdo <= rst_chain_ff;
      else if (ir_ff == jmpp_pkg::IR_UNLOCK)
        tdo <= unlock_sh_ff[0];
      else if (prog_cmd)
        tdo <= cmd_sh_ff[0]; // RQ13
      else if (prog_load || prog_read)
        tdo <= pg_sh_ff[0];
      else
        tdo <= bypass_ff;
    end

  // ---------------------------------------------------------------
  // Core side of the crossings
  // ---------------------------------------------------------------
  logic [2:0] cmd_sync_ff;
  logic [2:0] exec_sync_ff;
  logic [2:0] pl_sync_ff;
  logic [2:0] rdq_sync_ff;
  logic rd_pend_ff;

  always_ff @(posedge mclk or negedge mrst_n)
    if (!mrst_n)
    begin
      cmd_sync_ff <= 3'h0;
      exec_sync_ff <= 3'h0;
      pl_sync_ff <= 3'h0;
      rdq_sync_ff <= 3'h0;
    end
    else
    begin
      cmd_sync_ff <= {cmd_sync_ff[1:0], cmd_tgl_ff};
      exec_sync_ff <= {exec_sync_ff[1:0], exec_tgl_ff};
      pl_sync_ff <= {pl_sync_ff[1:0], pl_tgl_ff};
      rdq_sync_ff <= {rdq_sync_ff[1:0], rd_req_tgl_ff};
    end

  always_ff @(posedge mclk or negedge mrst_n)
    if (!mrst_n)
    begin
      flash_cmd <= jmpp_pkg::CMD_RESET;
      flash_cmd_load <= 1'b0;
      flash_exec <= 1'b0;
    end
    else
    begin
      flash_cmd_load <= cmd_sync_ff[2] != cmd_sync_ff[1]; // RQ14
      flash_exec <= exec_sync_ff[2] != exec_sync_ff[1]; // RQ15
      if (cmd_sync_ff[2] != cmd_sync_ff[1])
        flash_cmd <= cmd_ff;
    end

  always_ff @(posedge mclk or negedge mrst_n)
    if (!mrst_n)
    begin
      res_hold_ff <= jmpp_pkg::CMD_RESET;
      res_tgl_ff <= 1'b0;
    end
    else if (flash_result_valid)
    begin
      res_hold_ff <= flash_result; // RQ13
      res_tgl_ff <= ~res_tgl_ff;
    end

  always_ff @(posedge mclk or negedge mrst_n)
    if (!mrst_n)
    begin
      page_wr <= 1'b0;
      page_wr_addr <= 7'h00;
      page_wr_data <= 8'h00;
    end
    else
    begin
      page_wr <= pl_sync_ff[2] != pl_sync_ff[1]; // RQ17
      if (pl_sync_ff[2] != pl_sync_ff[1])
      begin
        page_wr_addr <= pl_idx_ff;
        page_wr_data <= pl_data_ff;
      end
    end

  // Address out one cycle, data taken the next
  always_ff @(posedge mclk or negedge mrst_n)
    if (!mrst_n)
    begin
      page_rd_addr <= 7'h00;
      rd_pend_ff <= 1'b0;
      rd_hold_ff <= 8'h00;
      rd_ack_tgl_ff <= 1'b0;
    end
    else
    begin
      rd_pend_ff <= rdq_sync_ff[2] != rdq_sync_ff[1];
      if (rdq_sync_ff[2] != rdq_sync_ff[1])
        page_rd_addr <= rd_idx_ff; // RQ19
      if (rd_pend_ff)
      begin
        rd_hold_ff <= page_rd_data;
        rd_ack_tgl_ff <= ~rd_ack_tgl_ff;
      end
    end

  assign test_port_disable_bit = disable_ff;
  assign core_reset = core_reset_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_cmd_update;
    tap_ff == jmpp_pkg::TAP_UPD_DR && prog_cmd;
  endsequence

  property p_ir_capture;
    @(posedge tck) disable iff (!trst_n)
    tap_ff == jmpp_pkg::TAP_CAP_IR |=> ir_sh_ff == jmpp_pkg::IR_CAPTURE_VAL;
  endproperty
  a_ir_capture: assert property (p_ir_capture) else $error("ir capture value wrong"); // RQ1

  property p_lsb_first;
    @(posedge tck) disable iff (!trst_n)
    shift_dr && prog_cmd |=> cmd_sh_ff[13:0] == $past(cmd_sh_ff[14:1]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("command not shifted lsb first"); // RQ2

  property p_unlock;
    @(posedge tck) disable iff (!trst_n)
    tap_ff == jmpp_pkg::TAP_UPD_DR && ir_ff == jmpp_pkg::IR_UNLOCK
      |=> unlocked_ff == ($past(unlock_sh_ff) == jmpp_pkg::UNLOCK_SIGNATURE);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock compare wrong"); // RQ10

  property p_capture_result;
    @(posedge tck) disable iff (!trst_n)
    tap_ff == jmpp_pkg::TAP_CAP_DR && prog_cmd |=> cmd_sh_ff == $past(res_ff);
  endproperty
  a_capture_result: assert property (p_capture_result) else $error("result not captured"); // RQ13

  property p_cmd_reaches_flash;
    @(posedge mclk) disable iff (!mrst_n)
    $changed(cmd_sync_ff[1]) |=> flash_cmd_load && flash_cmd == $past(cmd_ff);
  endproperty
  a_cmd_reaches_flash: assert property (p_cmd_reaches_flash) else $error("cmd lost"); // RQ14

  property p_cmd_update;
    @(posedge tck) disable iff (!trst_n)
    s_cmd_update |=> $changed(cmd_tgl_ff) && cmd_ff == $past(cmd_sh_ff);
  endproperty
  a_cmd_update: assert property (p_cmd_update) else $error("command not updated"); // RQ14

  property p_locked_ignored;
    @(posedge tck) disable iff (!trst_n)
    tap_ff == jmpp_pkg::TAP_UPD_DR && !unlocked_ff |=> $stable(cmd_tgl_ff) && $stable(pl_tgl_ff);
  endproperty
  a_locked_ignored: assert property (p_locked_ignored) else $error("locked op taken"); // RQ23

  property p_no_update_transfer;
    @(posedge tck) disable iff (!trst_n)
    tap_ff == jmpp_pkg::TAP_UPD_DR |=> $stable(pl_tgl_ff);
  endproperty
  a_no_update_transfer: assert property (p_no_update_transfer) else $error("update moved byte"); // RQ17

  property p_disable_clear;
    @(posedge mclk) disable iff (!mrst_n)
    (!ext_sync_ff[1]) [*2] |=> !disable_ff;
  endproperty
  a_disable_clear: assert property (p_disable_clear) else $error("disable bit kept"); // RQ4

  property p_core_reset;
    @(posedge mclk) disable iff (!mrst_n)
    chain_sync_ff[1] |=> core_reset_ff [*2];
  endproperty
  a_core_reset: assert property (p_core_reset) else $error("core reset late"); // RQ6

endmodule : jmpp_top

// ---- src/jmpp_pkg.sv ----
package jmpp_pkg;

  // ---------------------------------------------------------------
  // Widths and chain geometry
  // ---------------------------------------------------------------
  localparam int IR_W = 4;
  localparam int SIG_W = 16;
  localparam int CMD_W = 15;
  localparam int BYTE_W = 8;
  localparam int PAGE_BITS = 1024;
  localparam int PAGE_BYTES = PAGE_BITS / BYTE_W;
  localparam int PAGE_ADDR_W = $clog2(PAGE_BYTES);
  localparam int READ_PAD_BITS = 8;

  // ---------------------------------------------------------------
  // Instruction codes
  // ---------------------------------------------------------------
  localparam logic [3:0] IR_RESET_CHAIN = 4'hC;
  localparam logic [3:0] IR_UNLOCK = 4'h4;
  localparam logic [3:0] IR_COMMAND = 4'h5;
  localparam logic [3:0] IR_PAGE_LOAD = 4'h6;
  localparam logic [3:0] IR_PAGE_READ = 4'h7;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;

  // ---------------------------------------------------------------
  // Values and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] UNLOCK_SIGNATURE = 16'hA370;
  localparam logic [15:0] UNLOCK_RESET = 16'h0000;
  localparam logic [14:0] CMD_RESET = 15'h0000;
  localparam logic [1:0] EXT_RST_CLR_CYCLES = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TIMEOUT0_NS = 100;
  localparam int TIMEOUT1_NS = 1000;
  localparam int TIMEOUT2_NS = 10000;
  localparam int TIMEOUT3_NS = 40000;
  localparam int TO_W = 12;
  localparam logic [11:0] TIMEOUT0_CYC = 12'((TIMEOUT0_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] TIMEOUT1_CYC = 12'((TIMEOUT1_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] TIMEOUT2_CYC = 12'((TIMEOUT2_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] TIMEOUT3_CYC = 12'((TIMEOUT3_NS * CLK_MHZ + 999) / 1000);

  // ---------------------------------------------------------------
  // Test port controller states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jmpp_tap_type;

endpackage : jmpp_pkg

// ---- sim/jmpp_prog.sv ----
`timescale 1ns/100ps
// ----
// Programmer on the four test pins
// ----
module jmpp_prog (
  // Test pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  logic [1031:0] so;
  initial tck = 1'h0;
  initial tms = 1'h1;
  initial tdi = 1'h0;
  // Clock stands still between frames
  task step(input logic m, input logic v, output logic q);
    tms = m;
    tdi = v;
    #7.5;
    q = tdo;
    tck = 1'h1;
    #7.5;
    tck = 1'h0;
  endtask : step
  task seq(input int n, input logic [15:0] p);
    logic q;
    for (int i = 0; i < n; i++)
      step(p[i], 1'h0, q);
  endtask : seq
  // Lone device in the chain, so page chains are allowed
  task scan(input logic ir, input int n, input logic [1031:0] v);
    seq(ir ? 4 : 3, ir ? 16'h0003 : 16'h0001);
    for (int i = 0; i < n; i++)
      step(i == n - 1, v[i], so[i]);
    seq(2, 16'h0001);
  endtask : scan
endmodule : jmpp_prog

// ---- sim/jmpp_top_test.sv ----
`timescale 1ns/100ps
module jmpp_top_test;
  // ----
  // Bench state
  // ----
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic ext_n = 1'h1;
  logic dwr = 1'h0;
  logic dwd = 1'h0;
  logic rv = 1'h0;
  logic fuse = 1'h1;
  logic [14:0] res = 15'h0000;
  logic [14:0] fc, cmd;
  logic tck, tms, tdi, tdo, oe, wr, ld, ex, crst, dis;
  logic [6:0] rd_a, wr_a;
  logic [7:0] wr_d;
  logic [7:0] mem [128];
  logic [1031:0] d = '0;
  int n_errors, checked, cyc, n_ld, n_ex, n_wr, e0;
  always #5 mclk = ~mclk;
  jmpp_top dut_u (.mclk(mclk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(oe), .ext_rst_n(ext_n), .test_port_enable_fuse(fuse),
    .clk_option_fuse(2'h0), .disable_wr(dwr), .disable_wdata(dwd),
    .test_port_disable_bit(dis), .core_reset(crst), .flash_cmd(fc),
    .flash_cmd_load(ld), .flash_exec(ex), .flash_result_valid(rv),
    .flash_result(res), .page_wr(wr), .page_wr_addr(wr_a), .page_wr_data(wr_d),
    .page_rd_addr(rd_a), .page_rd_data(mem[rd_a]));
  // Undriven pin reads inverted, so a late output enable spoils the reads
  jmpp_prog prog_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(oe ? tdo : ~tdo));
  // ----
  // Page buffer model and pulse counters
  // ----
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    n_ld <= n_ld + int'(ld);
    n_ex <= n_ex + int'(ex);
    n_wr <= n_wr + int'(wr);
    if (wr)
      mem[wr_a] <= wr_d;
    if (cyc == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    @(negedge mclk);
    checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task ir(input logic [3:0] v);
    prog_u.scan(1'h1, 4, 1032'(v));
  endtask : ir
  // Slack for the crossing into the system clock
  task dr(input int n, input logic [1031:0] v);
    prog_u.scan(1'h0, n, v);
    repeat (6) @(negedge mclk);
  endtask : dr
  task tally_and_finish;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    void'($urandom(52399));
    fork
      repeat (6) @(posedge mclk);
      prog_u.seq(4, 16'h000F);
    join
    @(negedge mclk) rst_n = 1'h1;
    prog_u.seq(8, 16'h007F);
    @(negedge mclk) {dwr, dwd} = 2'h3;
    @(negedge mclk) dwr = 1'h0;
    chk("disable", dis, 1'h1);
    ext_n = 1'h0;
    repeat (6) @(negedge mclk);
    chk("disable", dis, 1'h0);
    ext_n = 1'h1;
    prog_u.seq(8, 16'h007F);
    $display("test disable done");
    ir(4'hC);
    chk("ir_capture", prog_u.so[3:0], 4'h1);
    dr(1, 1'h1);
    chk("core_reset", crst, 1'h1);
    prog_u.scan(1'h0, 1, 1'h0);
    chk("core_reset", crst, 1'h1);
    repeat (20) @(negedge mclk);
    chk("core_reset", crst, 1'h0);
    $display("test reset chain done");
    fuse = 1'h0;
    dr(1, 1'h1);
    chk("port_off", crst, 1'h0);
    fuse = 1'h1;
    prog_u.seq(4, 16'h0007);
    ir(4'hC);
    dr(1, 1'h1);
    $display("test port off done");
    ir(4'h4);
    dr(16, 16'hA371);
    ir(4'h5);
    dr(15, 15'h2310);
    chk("locked_load", n_ld + n_ex, 0);
    $display("test locked done");
    ir(4'h4);
    dr(16, 16'hA370);
    cmd = 15'($urandom);
    ir(4'h5);
    e0 = n_ex;
    dr(15, 1032'(cmd));
    chk("cmd", fc, cmd);
    chk("exec", n_ex - e0, 1);
    @(negedge mclk) {rv, res} = {1'h1, 15'($urandom)};
    @(negedge mclk) rv = 1'h0;
    prog_u.seq(4, 16'h0000);
    dr(15, 15'h2310);
    chk("result", prog_u.so[14:0], res);
    chk("cmd", fc, 15'h2310);
    chk("loads", n_ld, 2);
    $display("test command done");
    for (int i = 0; i < 32; i++)
      d[32*i +: 32] = $urandom;
    ir(4'h6);
    dr(1024, d);
    chk("page_writes", n_wr, 128);
    // Inverted input must not leak into the read chain
    ir(4'h7);
    dr(1032, ~d);
    chk("pad", prog_u.so[7:0], 8'h00);
    for (int i = 0; i < 128; i++)
      chk("page_byte", prog_u.so[8 + 8*i +: 8], d[8*i +: 8]);
    $display("test page done");
    ir(4'h4);
    dr(16, 16'h0000);
    ir(4'h5);
    dr(15, 15'h2310);
    chk("relock", n_ld, 2);
    $display("test relock done");
    tally_and_finish();
  end
endmodule : jmpp_top_test
